// file: rtl/qsadc_map.svh
// qsadc_map.svh: timing counts and widths of the four-input sampling converter sequencer
// assumes a single 100 MHz clock shared by both ends
`ifndef QSADC_MAP_SVH
`define QSADC_MAP_SVH

`define QSADC_CLK_NS 10
`define QSADC_CHANNELS 4
`define QSADC_WORD_BITS 12
`define QSADC_FIFO_DEPTH 8
// per-channel conversion time, least figure rounds up
`define QSADC_CONV_NS 1650
`define QSADC_CONV_CYCLES ((`QSADC_CONV_NS + `QSADC_CLK_NS - 1) / `QSADC_CLK_NS)
// track time the host must leave after busy falls
`define QSADC_ACQ_NS 350
`define QSADC_ACQ_CYCLES ((`QSADC_ACQ_NS + `QSADC_CLK_NS - 1) / `QSADC_CLK_NS)
// start spacing: 500 kSPS one channel, 130 kSPS more channels
`define QSADC_ONE_PERIOD_NS 2000
`define QSADC_ONE_PERIOD_CYCLES ((`QSADC_ONE_PERIOD_NS + `QSADC_CLK_NS - 1) / `QSADC_CLK_NS)
`define QSADC_MULTI_PERIOD_NS 7693
`define QSADC_MULTI_PERIOD_CYCLES ((`QSADC_MULTI_PERIOD_NS + `QSADC_CLK_NS - 1) / `QSADC_CLK_NS)
// gap the host leaves between two read strobes
`define QSADC_READ_GAP_CYCLES 2

`endif

// file: rtl/qsadc_pkg.sv
// qsadc_pkg: types shared by both ends of the converter sequencer
// assumes qsadc_map.svh is on the include path
`include "qsadc_map.svh"
package qsadc_pkg;
  typedef logic [`QSADC_WORD_BITS-1:0] qsadc_word_t;
  typedef logic [`QSADC_CHANNELS-1:0] qsadc_mask_t;
  typedef logic [1:0] qsadc_chan_t;

  typedef enum logic [1:0] {
    QSADC_DEV_IDLE = 2'b00,
    QSADC_DEV_CONV = 2'b01,
    QSADC_DEV_PUSH = 2'b10
  } qsadc_dev_state_t;

  typedef enum logic [1:0] {
    QSADC_RD_IDLE = 2'b00,
    QSADC_RD_STROBE = 2'b01,
    QSADC_RD_CAPTURE = 2'b10,
    QSADC_RD_GAP = 2'b11
  } qsadc_rd_state_t;
endpackage

// file: rtl/qsadc_if.sv
// qsadc_if: pins between the converter device and its host
// assumes both ends run on the same mclk
`timescale 1ns/10ps
interface qsadc_if;
  // conversion control
  logic conversion_start_pulse;
  logic sel_by_software;
  qsadc_pkg::qsadc_mask_t chan_sel_pins;
  logic sel_write_n;
  qsadc_pkg::qsadc_mask_t sel_write_data;
  // progress
  logic conv_done_n;
  logic busy;
  // parallel readout
  logic cs_n;
  logic rd_n;
  qsadc_pkg::qsadc_word_t data;

  modport device (
    input conversion_start_pulse, sel_by_software, chan_sel_pins, sel_write_n, sel_write_data, cs_n, rd_n,
    output conv_done_n, busy, data
  );
  modport host (
    output conversion_start_pulse, sel_by_software, chan_sel_pins, sel_write_n, sel_write_data, cs_n, rd_n,
    input conv_done_n, busy, data
  );
endinterface

// file: rtl/qsadc_device.sv
// qsadc_device: sequencing and readout end of the four-input sampling converter
// assumes the host shares mclk and drives the device modport; analog levels arrive pre-digitised
// Behaviour
// - convert only selected channels, skip others
// - selection from pins or written register
// - one start holds all four samples
// - pulse done after each channel conversion
// - busy high for whole sequence
// - 12-bit words read by select and read
// - each channel takes fixed conversion time
// - host waits acquisition time after busy
// - host keeps start rate within throughput
// - read during or after the sequence
`timescale 1ns/10ps
`include "qsadc_map.svh"

module qsadc_fifo #(
  parameter int WIDTH = `QSADC_WORD_BITS,
  parameter int DEPTH = `QSADC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap by hand so a depth that is not a power of two still works
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module qsadc_device #(
  parameter int CONV_CYCLES = `QSADC_CONV_CYCLES,
  parameter int FIFO_DEPTH = `QSADC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // link to the host
  qsadc_if.device link,
  // digitised analog inputs, one word per channel
  input wire qsadc_pkg::qsadc_word_t analog_in [`QSADC_CHANNELS],
  // observed state
  output qsadc_pkg::qsadc_mask_t held_mask
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  qsadc_pkg::qsadc_dev_state_t state;
  qsadc_pkg::qsadc_mask_t sw_select;
  qsadc_pkg::qsadc_mask_t pending;
  qsadc_pkg::qsadc_chan_t chan;
  qsadc_pkg::qsadc_word_t held [`QSADC_CHANNELS];
  qsadc_pkg::qsadc_word_t result;
  qsadc_pkg::qsadc_word_t data_q;
  logic [CW-1:0] conv_cnt;
  logic done_n;

  // lowest pending channel converts first
  function automatic qsadc_pkg::qsadc_chan_t first_chan(input qsadc_pkg::qsadc_mask_t m);
    qsadc_pkg::qsadc_chan_t c;
    c = 2'h0;
    for (int i = `QSADC_CHANNELS - 1; i >= 0; i--) begin
      if (m[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction

  wire qsadc_pkg::qsadc_mask_t active_select = link.sel_by_software ? sw_select : link.chan_sel_pins;
  wire start_taken = link.conversion_start_pulse && (state == qsadc_pkg::QSADC_DEV_IDLE) && (active_select != '0);
  wire conv_end = (state == qsadc_pkg::QSADC_DEV_CONV) && (conv_cnt == CW'(CONV_CYCLES - 1));
  wire push_valid = (state == qsadc_pkg::QSADC_DEV_PUSH);
  wire push_ready;
  wire pushed = push_valid && push_ready;
  wire rd_strobe = !link.cs_n && !link.rd_n;
  wire fifo_valid;
  wire qsadc_pkg::qsadc_word_t fifo_data;
  wire qsadc_pkg::qsadc_mask_t next_pending = pending & ~(qsadc_pkg::qsadc_mask_t'(1) << chan);

  // results wait here so the host may read during or after the sequence
  qsadc_fifo #(
    .WIDTH(`QSADC_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(result),
    .out_valid(fifo_valid),
    .out_ready(rd_strobe),
    .out_data(fifo_data)
  );

  assign link.busy = (state != qsadc_pkg::QSADC_DEV_IDLE);
  assign link.conv_done_n = done_n;
  assign link.data = data_q;
  assign held_mask = pending;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sw_select <= 4'hF;
    end else if (!link.sel_write_n) begin
      sw_select <= link.sel_write_data;
    end
  end

  // all four channels freeze on the same edge
  always_ff @(posedge mclk) begin
    if (start_taken) begin
      held <= analog_in;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= qsadc_pkg::QSADC_DEV_IDLE;
      pending <= '0;
      chan <= 2'h0;
      conv_cnt <= '0;
      result <= 12'h000;
    end else begin
      case (state)
        qsadc_pkg::QSADC_DEV_IDLE: begin
          conv_cnt <= '0;
          if (start_taken) begin
            pending <= active_select;
            chan <= first_chan(active_select);
            state <= qsadc_pkg::QSADC_DEV_CONV;
          end
        end
        qsadc_pkg::QSADC_DEV_CONV: begin
          conv_cnt <= conv_cnt + 1'b1;
          if (conv_end) begin
            result <= held[chan];
            state <= qsadc_pkg::QSADC_DEV_PUSH;
          end
        end
        qsadc_pkg::QSADC_DEV_PUSH: begin
          // a full buffer stalls the sequence instead of losing a result
          conv_cnt <= '0;
          if (pushed) begin
            pending <= next_pending;
            chan <= first_chan(next_pending);
            state <= (next_pending == '0) ? qsadc_pkg::QSADC_DEV_IDLE : qsadc_pkg::QSADC_DEV_CONV;
          end
        end
        default: begin
          state <= qsadc_pkg::QSADC_DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done_n <= 1'b1;
      data_q <= 12'h000;
    end else begin
      done_n <= !pushed;
      if (rd_strobe && fifo_valid) begin
        data_q <= fifo_data;
      end
    end
  end
endmodule

// file: rtl/qsadc_host.sv
// qsadc_host: host end that starts sequences and reads results of the converter
// assumes the device shares mclk; inputs from it need no synchroniser
`timescale 1ns/10ps
`include "qsadc_map.svh"

module qsadc_host #(
  parameter int ACQ_CYCLES = `QSADC_ACQ_CYCLES,
  parameter int ONE_PERIOD = `QSADC_ONE_PERIOD_CYCLES,
  parameter int MULTI_PERIOD = `QSADC_MULTI_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // link to the device
  qsadc_if.host link,
  // sequence requests
  input wire logic start_req,
  output logic start_ready,
  input wire logic use_software_sel,
  input wire qsadc_pkg::qsadc_mask_t chan_mask,
  input wire logic sel_write_req,
  input wire logic read_after_seq,
  // results
  output logic result_valid,
  output qsadc_pkg::qsadc_word_t result_data
);
  localparam int TW = $clog2(MULTI_PERIOD + 1);

  qsadc_pkg::qsadc_rd_state_t rd_state;
  logic [TW-1:0] period_cnt;
  logic [TW-1:0] acq_cnt;
  logic [3:0] owed;
  logic busy_q;
  logic rd_gap;
  logic sel_wr_n;
  qsadc_pkg::qsadc_mask_t sel_data;
  qsadc_pkg::qsadc_mask_t written_mask;
  qsadc_pkg::qsadc_word_t result_q;
  logic result_v;
  logic [1:0] gap_cnt;

  function automatic logic [2:0] bit_count(input qsadc_pkg::qsadc_mask_t m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `QSADC_CHANNELS; i++) begin
      n = n + 3'(m[i]);
    end
    return n;
  endfunction

  wire busy_fall = busy_q && !link.busy;
  wire done_seen = !link.conv_done_n;
  // with software selection the pins say nothing, so pace by the mask last written
  wire qsadc_pkg::qsadc_mask_t rate_mask = use_software_sel ? written_mask : chan_mask;
  wire multi = (bit_count(rate_mask) > 3'h1);
  wire [TW-1:0] period = multi ? TW'(MULTI_PERIOD) : TW'(ONE_PERIOD);
  // start waits out both the rate limit and the track time after busy falls
  assign start_ready = !link.busy && !busy_q && (period_cnt == '0) && (acq_cnt == '0);
  wire start_fire = start_req && start_ready;
  wire may_read = (owed != 4'h0) && (!read_after_seq || !link.busy);
  wire strobe = (rd_state == qsadc_pkg::QSADC_RD_STROBE);

  assign link.conversion_start_pulse = start_fire;
  assign link.sel_by_software = use_software_sel;
  assign link.chan_sel_pins = chan_mask;
  assign link.sel_write_n = sel_wr_n;
  assign link.sel_write_data = sel_data;
  assign link.cs_n = !strobe;
  assign link.rd_n = !strobe;
  assign result_valid = result_v;
  assign result_data = result_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      period_cnt <= '0;
      acq_cnt <= '0;
      sel_wr_n <= 1'b1;
      sel_data <= 4'hF;
      written_mask <= 4'hF;
    end else begin
      busy_q <= link.busy;
      if (!sel_wr_n) begin
        written_mask <= sel_data;
      end
      sel_wr_n <= !(sel_write_req && !link.busy);
      sel_data <= chan_mask;
      if (start_fire) begin
        period_cnt <= period - 1'b1;
      end else if (period_cnt != '0) begin
        period_cnt <= period_cnt - 1'b1;
      end
      if (busy_fall) begin
        acq_cnt <= TW'(ACQ_CYCLES - 1);
      end else if (acq_cnt != '0) begin
        acq_cnt <= acq_cnt - 1'b1;
      end
    end
  end

  // owed counts results announced by done but not yet read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      owed <= 4'h0;
      rd_state <= qsadc_pkg::QSADC_RD_IDLE;
      result_q <= 12'h000;
      result_v <= 1'b0;
      gap_cnt <= 2'h0;
    end else begin
      owed <= owed + 4'(done_seen) - 4'(strobe);
      result_v <= 1'b0;
      case (rd_state)
        qsadc_pkg::QSADC_RD_IDLE: begin
          if (may_read) begin
            rd_state <= qsadc_pkg::QSADC_RD_STROBE;
          end
        end
        qsadc_pkg::QSADC_RD_STROBE: begin
          rd_state <= qsadc_pkg::QSADC_RD_CAPTURE;
        end
        qsadc_pkg::QSADC_RD_CAPTURE: begin
          result_q <= link.data;
          result_v <= 1'b1;
          gap_cnt <= 2'(`QSADC_READ_GAP_CYCLES - 1);
          rd_state <= qsadc_pkg::QSADC_RD_GAP;
        end
        qsadc_pkg::QSADC_RD_GAP: begin
          if (gap_cnt == 2'h0) begin
            rd_state <= qsadc_pkg::QSADC_RD_IDLE;
          end else begin
            gap_cnt <= gap_cnt - 1'b1;
          end
        end
        default: begin
          rd_state <= qsadc_pkg::QSADC_RD_IDLE;
        end
      endcase
    end
  end
endmodule

// file: dv/qsadc_props.sv
// qsadc_props: assertions on the link between host and device ends
// assumes conversion shortened to 4 cycles, acquisition to 2, start spacing to 8
`timescale 1ns/10ps
module qsadc_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // host to device
  input wire logic conversion_start_pulse,
  input wire logic sel_by_software,
  input wire qsadc_pkg::qsadc_mask_t chan_sel_pins,
  input wire logic sel_write_n,
  input wire qsadc_pkg::qsadc_mask_t sel_write_data,
  input wire logic cs_n,
  input wire logic rd_n,
  // device to host
  input wire logic conv_done_n,
  input wire logic busy,
  input wire qsadc_pkg::qsadc_word_t data
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire read_strobe = !cs_n && !rd_n;
  // software selection hides the mask, so the busy-on-start checks use pin selection only
  wire hw_start = conversion_start_pulse && !busy && !sel_by_software;
  chk_start_goes_busy: assert property (
    hw_start && (chan_sel_pins != 4'h0) |=> busy) else $error("selected start left busy low");
  chk_empty_mask_idle: assert property (
    hw_start && (chan_sel_pins == 4'h0) |=> !busy) else $error("empty selection started");
  chk_done_in_seq: assert property (
    $fell(conv_done_n) |-> busy || $past(busy) || $past(busy, 2)) else $error("done outside sequence");
  chk_done_single: assert property (
    !conv_done_n |=> conv_done_n) else $error("done held over one cycle");
  chk_conv_time: assert property (
    $rose(busy) |-> conv_done_n [*4]) else $error("done before conversion time");
  chk_seq_ends: assert property (
    $rose(busy) |-> ##[4:400] !busy) else $error("busy never released");
  chk_data_on_strobe: assert property (
    !$stable(data) |-> $past(read_strobe)) else $error("data moved without strobe");
  chk_read_spacing: assert property (
    read_strobe |=> !read_strobe [*3]) else $error("read strobes too close");
  chk_start_spacing: assert property (
    conversion_start_pulse |=> !conversion_start_pulse [*7]) else $error("starts too close");
  chk_acq_after_busy: assert property (
    $fell(busy) |-> !conversion_start_pulse [*2]) else $error("start inside acquisition");
  chk_sel_write_idle: assert property (
    !sel_write_n |-> !$past(busy)) else $error("select written while busy");
  cover property (conversion_start_pulse && !busy);
  cover property (!conv_done_n);
  cover property (read_strobe && busy);
  cover property (!sel_write_n);
endmodule

// file: dv/test_quad_sample_adc_sequencer.sv
// test_quad_sample_adc_sequencer: both ends joined, random and corner sequences
// assumes shortened counts; results are compared in conversion order
`timescale 1ns/10ps
module test_quad_sample_adc_sequencer;
  logic mclk;
  logic reset;
  logic start_req;
  logic start_ready;
  logic use_software_sel;
  qsadc_pkg::qsadc_mask_t chan_mask;
  logic sel_write_req;
  logic read_after_seq;
  logic result_valid;
  qsadc_pkg::qsadc_word_t result_data;
  qsadc_pkg::qsadc_word_t analog_in [4];
  qsadc_pkg::qsadc_mask_t held_mask;
  qsadc_pkg::qsadc_word_t exp_q [$];
  logic [5:0] corner [6] = '{6'h01, 6'h28, 6'h1F, 6'h00, 6'h35, 6'h2F};
  logic [31:0] seed;
  int bad_count;
  int n_checks;
  int got;
  int dones;
  int cycles;
  qsadc_if i_qsadc_if ();
  qsadc_device #(.CONV_CYCLES(4), .FIFO_DEPTH(8)) i_qsadc_device (.mclk(mclk), .reset(reset),
    .link(i_qsadc_if), .analog_in(analog_in), .held_mask(held_mask));
  qsadc_host #(.ACQ_CYCLES(2), .ONE_PERIOD(8), .MULTI_PERIOD(20)) i_qsadc_host (.mclk(mclk),
    .reset(reset), .link(i_qsadc_if), .start_req(start_req), .start_ready(start_ready),
    .use_software_sel(use_software_sel), .chan_mask(chan_mask), .sel_write_req(sel_write_req),
    .read_after_seq(read_after_seq), .result_valid(result_valid), .result_data(result_data));
  qsadc_props i_qsadc_props (.mclk(mclk), .reset(reset),
    .conversion_start_pulse(i_qsadc_if.conversion_start_pulse), .sel_by_software(i_qsadc_if.sel_by_software),
    .chan_sel_pins(i_qsadc_if.chan_sel_pins), .sel_write_n(i_qsadc_if.sel_write_n),
    .sel_write_data(i_qsadc_if.sel_write_data), .cs_n(i_qsadc_if.cs_n), .rd_n(i_qsadc_if.rd_n),
    .conv_done_n(i_qsadc_if.conv_done_n), .busy(i_qsadc_if.busy), .data(i_qsadc_if.data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function logic [11:0] rnd_word();
    seed = xs(seed);
    return seed[11:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic run_seq(input qsadc_pkg::qsadc_mask_t m, input logic sw, input logic after);
    int n;
    int w;
    n = 0;
    use_software_sel = sw;
    read_after_seq = after;
    chan_mask = m;
    if (sw) begin
      sel_write_req = 1'b1;
      @(posedge mclk);
      #1 sel_write_req = 1'b0;
      repeat (3) @(posedge mclk);
      // pins now disagree, so only the written register can give m
      #1 chan_mask = ~m;
    end
    for (int i = 0; i < 4; i++) begin
      analog_in[i] = rnd_word();
      if (m[i]) begin
        exp_q.push_back(analog_in[i]);
        n++;
      end
    end
    got = 0;
    dones = 0;
    start_req = 1'b1;
    w = 0;
    while (start_ready !== 1'b1 && w < 1000) begin
      @(posedge mclk);
      #1 w++;
    end
    @(posedge mclk);
    #1 start_req = 1'b0;
    check({12'h000, held_mask}, {12'h000, m});
    check({15'h0000, start_ready}, 16'h0000);
    // later input must not reach results: all four were held on the start edge
    for (int i = 0; i < 4; i++) begin
      analog_in[i] = rnd_word();
    end
    w = 0;
    while (exp_q.size() != 0 && w < 2000) begin
      @(posedge mclk);
      w++;
    end
    repeat (40) @(posedge mclk);
    #1;
    check(16'(got), 16'(n));
    check(16'(dones), 16'(n));
    check({15'h0000, i_qsadc_if.busy}, 16'h0000);
  endtask

  always @(posedge mclk) begin
    if (i_qsadc_if.conv_done_n === 1'b0) begin
      dones++;
    end
    if (result_valid === 1'b1) begin
      got++;
      if (exp_q.size() == 0) begin
        check({4'h0, result_data}, 16'hFFFF);
      end else begin
        check({4'h0, result_data}, {4'h0, exp_q.pop_front()});
      end
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    seed = 32'h0000_0012;
    reset = 1'b1;
    start_req = 1'b0;
    use_software_sel = 1'b0;
    chan_mask = 4'hF;
    sel_write_req = 1'b0;
    read_after_seq = 1'b0;
    analog_in = '{12'h000, 12'h000, 12'h000, 12'h000};
    bad_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    for (int t = 0; t < 20; t++) begin
      if (t < 6) begin
        run_seq(corner[t][3:0], corner[t][4], corner[t][5]);
      end else begin
        seed = xs(seed);
        run_seq(seed[3:0], seed[4], seed[5]);
      end
      $display("test %0d finished", t);
    end
    tally_and_finish;
  end
endmodule
